// [src/sps_pkg.sv]
// Package for the serial PHY indirect access block: map, fields, types
package sps_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [15:0] SPS_IDX_DATA = 16'hd100;
    localparam logic [15:0] SPS_IDX_ADDR = 16'hd101;
    localparam logic [15:0] SPS_IDX_CTRL = 16'hd102;
    localparam logic [15:0] SPS_IDX_STATUS = 16'hd10a;
    localparam logic [15:0] SPS_IDX_WD_CTRL = 16'hd111;
    localparam logic [15:0] SPS_IDX_WD_TIMER = 16'hd112;

    // Control register fields
    localparam int SPS_CTL_RESET_LOW = 12;
    localparam int SPS_CTL_WRITE_START = 8;
    localparam int SPS_CTL_READ_START = 4;
    localparam int SPS_CTL_DONE = 0;
    // Watchdog control fields
    localparam int SPS_WD_EN = 1;
    localparam int SPS_WD_ERR = 0;

    // Reset values
    localparam logic [15:0] SPS_DATA_RST = 16'h0000;
    localparam logic [15:0] SPS_ADDR_RST = 16'h0000;
    localparam logic [15:0] SPS_WD_TIMER_RST = 16'hffff;
    localparam logic [11:0] SPS_STATUS_RST = 12'h000;

    // Status inputs, packed in status word bit order 11..0
    typedef struct packed {
        logic [4:0] bringup_state;
        logic transmitter_ready_flag;
        logic receiver_detect_result;
        logic receiver_detect_ack;
        logic tx_common_mode_ack;
        logic rx_pll_ack;
        logic rx_signal_lost;
        logic main_pll_ack;
    } sps_phy_stat_type;

    // Request towards the PHY register space
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } sps_phy_req_type;

    typedef enum logic [0:0] {
        SPS_IDLE,
        SPS_BUSY
    } sps_acc_state_type;

    typedef struct packed {
        logic ph_valid;
        logic ph_write;
        logic [15:0] ph_idx;
        logic rd_wait;
        logic [31:0] hrdata;
        logic [15:0] data;
        logic [15:0] addr;
        logic fsm_run;
        logic done;
        logic wr_start;
        logic rd_start;
        sps_acc_state_type st;
        logic [15:0] reload;
        logic [15:0] count;
        logic wd_en;
        logic wd_err;
        sps_phy_stat_type sync1;
        sps_phy_stat_type sync2;
    } sps_state_type;
endpackage

// [src/sps_indirect_access.sv]
// Serial PHY indirect access engine, status mirror and watchdog
//
// Behaviour
// - Finished read leaves fetched value in data
// - Address register holds target, reads back
// - Control bit 8 writes data to address
// - Control bit 4 reads address; self-clears
// - Starting a transaction clears done flag
// - Done sets at finish, holds until restart or control bit 12 low
// - Control bit 12 low resets access machine
// - Watchdog control bit 1 enables timer
// - Watchdog control bit 0 reports error
// - Watchdog timer value resets to ffff
// - Status 11:7 mirror bring-up machine state
// - Status 6 shows transmitter ready
// - Status 5 detect result, valid with ack
// - Status 3,2,0 show cm, rx, main pll acks
// - Status 1 shows receive loss of signal
`timescale 1ns/1ps
module sps_indirect_access
    import sps_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // PHY register space access
    output sps_phy_req_type phy_req_o,
    input wire logic phy_ack_i,
    input wire logic [15:0] phy_rdata_i,
    // PHY macro status levels, asynchronous
    input wire sps_phy_stat_type phy_status_i
);

    localparam sps_state_type RESET_STATE = '{
        ph_valid: 1'b0,
        ph_write: 1'b0,
        ph_idx: 16'h0000,
        rd_wait: 1'b0,
        hrdata: 32'h0000_0000,
        data: SPS_DATA_RST,
        addr: SPS_ADDR_RST,
        fsm_run: 1'b1,
        done: 1'b0,
        wr_start: 1'b0,
        rd_start: 1'b0,
        st: SPS_IDLE,
        reload: SPS_WD_TIMER_RST,
        count: SPS_WD_TIMER_RST,
        wd_en: 1'b0,
        wd_err: 1'b0,
        sync1: SPS_STATUS_RST,
        sync2: SPS_STATUS_RST
    };

    sps_state_type s;
    sps_state_type next_s;
    logic wr_phase;
    logic ctl_wr;
    logic go;

    // Word-aligned register index from a byte address
    function automatic logic [15:0] word_index(input logic [31:0] a);
        word_index = a[17:2];
    endfunction

    function automatic logic [31:0] read_mux(input sps_state_type r);
        logic [15:0] v;
        v = 16'h0000;
        case (r.ph_idx)
            SPS_IDX_DATA: v = r.data;
            SPS_IDX_ADDR: v = r.addr;
            SPS_IDX_CTRL: begin
                v[SPS_CTL_RESET_LOW] = r.fsm_run;
                v[SPS_CTL_WRITE_START] = r.wr_start;
                v[SPS_CTL_READ_START] = r.rd_start;
                v[SPS_CTL_DONE] = r.done;
            end
            SPS_IDX_STATUS: v = {4'h0, r.sync2};
            SPS_IDX_WD_CTRL: begin
                v[SPS_WD_EN] = r.wd_en;
                v[SPS_WD_ERR] = r.wd_err;
            end
            SPS_IDX_WD_TIMER: v = r.reload;
            default: v = 16'h0000;
        endcase
        read_mux = {16'h0000, v};
    endfunction

    assign wr_phase = s.ph_valid && s.ph_write;
    assign ctl_wr = wr_phase && s.ph_idx == SPS_IDX_CTRL;
    // Starts need the machine out of reset, both before and after the write
    assign go = ctl_wr && s.fsm_run && hwdata_i[SPS_CTL_RESET_LOW] &&
        (hwdata_i[SPS_CTL_WRITE_START] || hwdata_i[SPS_CTL_READ_START]);

    // Reads take one wait state so the data word comes from a flop
    assign hreadyout_o = !(s.ph_valid && !s.ph_write && !s.rd_wait);
    assign hresp_o = 1'b0;
    assign hrdata_o = s.hrdata;
    assign phy_req_o = '{
        valid: s.st == SPS_BUSY,
        write: s.wr_start,
        addr: s.addr,
        wdata: s.data
    };

    always_comb begin
        next_s = s;

        // Address phase capture
        if (hready_i) begin
            next_s.ph_valid = hsel_i && htrans_i[1];
            next_s.ph_write = hwrite_i;
            next_s.ph_idx = word_index(haddr_i);
            next_s.rd_wait = 1'b0;
        end
        if (s.ph_valid && !s.ph_write && !s.rd_wait) begin
            next_s.hrdata = read_mux(s);
            next_s.rd_wait = 1'b1;
        end

        // Two-flop synchroniser for the macro status levels
        next_s.sync1 = phy_status_i;
        next_s.sync2 = s.sync1;

        // Register writes; hardware updates below take priority
        if (wr_phase) begin
            case (s.ph_idx)
                SPS_IDX_DATA: next_s.data = hwdata_i[15:0];
                SPS_IDX_ADDR: next_s.addr = hwdata_i[15:0];
                SPS_IDX_CTRL: begin
                    next_s.fsm_run = hwdata_i[SPS_CTL_RESET_LOW];
                end
                SPS_IDX_WD_CTRL: begin
                    next_s.wd_en = hwdata_i[SPS_WD_EN];
                    if (!hwdata_i[SPS_WD_EN]) begin
                        next_s.wd_err = 1'b0;
                    end
                end
                SPS_IDX_WD_TIMER: next_s.reload = hwdata_i[15:0];
                default: next_s.reload = s.reload;
            endcase
        end

        // Access machine; held in its reset state while bit 12 is low
        if (!next_s.fsm_run) begin
            next_s.st = SPS_IDLE;
            next_s.done = 1'b0;
            next_s.wr_start = 1'b0;
            next_s.rd_start = 1'b0;
        end else begin
            case (s.st)
                SPS_IDLE: begin
                    if (go) begin
                        next_s.st = SPS_BUSY;
                        next_s.done = 1'b0;
                        // Write wins if both start bits are set
                        next_s.wr_start = hwdata_i[SPS_CTL_WRITE_START];
                        next_s.rd_start = !hwdata_i[SPS_CTL_WRITE_START];
                        next_s.count = s.reload;
                    end
                end
                SPS_BUSY: begin
                    // Further starts are not looked at while busy
                    if (phy_ack_i) begin
                        if (s.rd_start) begin
                            next_s.data = phy_rdata_i;
                        end
                        next_s.done = 1'b1;
                        next_s.wr_start = 1'b0;
                        next_s.rd_start = 1'b0;
                        next_s.st = SPS_IDLE;
                    end else if (s.wd_en) begin
                        if (s.count == 16'h0000) begin
                            // Abort so software polling done is not hung
                            next_s.wd_err = 1'b1;
                            next_s.done = 1'b1;
                            next_s.wr_start = 1'b0;
                            next_s.rd_start = 1'b0;
                            next_s.st = SPS_IDLE;
                        end else begin
                            next_s.count = s.count - 16'h0001;
                        end
                    end
                end
                default: next_s.st = SPS_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    logic busy;
    logic fsm_clear;
    logic wd_fire;
    logic rd_data_ph;
    assign busy = s.st == SPS_BUSY;
    // Cases where hardware legally ends or blocks an access early, plus the read data phase
    assign fsm_clear = ctl_wr && !hwdata_i[SPS_CTL_RESET_LOW];
    assign wd_fire = busy && s.wd_en && s.count == 16'h0000 && !phy_ack_i;
    assign rd_data_ph = s.ph_valid && !s.ph_write && !s.rd_wait;

    chk_read_result: assert property (
        busy && !s.wr_start && phy_ack_i && !fsm_clear |=>
            s.data == $past(phy_rdata_i) && s.done && !s.rd_start)
        else $error("read result not stored in data register");

    chk_addr_store: assert property (
        wr_phase && s.ph_idx == SPS_IDX_ADDR |=>
            s.addr == $past(hwdata_i[15:0]))
        else $error("address register did not take written value");

    chk_write_issue: assert property (
        !busy && go && hwdata_i[SPS_CTL_WRITE_START] |=>
            phy_req_o.valid && phy_req_o.write &&
            phy_req_o.wdata == $past(s.data) &&
            phy_req_o.addr == $past(s.addr))
        else $error("write start did not issue phy write");

    chk_read_issue: assert property (
        !busy && go && !hwdata_i[SPS_CTL_WRITE_START] |=>
            phy_req_o.valid && !phy_req_o.write && s.rd_start)
        else $error("read start did not issue phy read");

    chk_start_clears: assert property (
        !busy && go |=> !s.done && busy)
        else $error("done flag not cleared at start");

    chk_done_holds: assert property (
        s.done && !busy && !go && !(ctl_wr &&
            !hwdata_i[SPS_CTL_RESET_LOW]) |=> s.done)
        else $error("done flag dropped without restart");

    chk_fsm_reset: assert property (
        ctl_wr && !hwdata_i[SPS_CTL_RESET_LOW] |=>
            !busy && !s.done ##1 !busy)
        else $error("control bit 12 low did not reset access machine");

    chk_wd_hold: assert property (
        busy && !s.wd_en && !phy_ack_i |=> s.count == $past(s.count))
        else $error("watchdog counted while disabled");

    chk_wd_expire: assert property (
        wd_fire && !fsm_clear |=>
            s.wd_err && s.done && !busy)
        else $error("watchdog expiry not flagged");

    chk_wd_err_sticky: assert property (
        s.wd_err && !(wr_phase && s.ph_idx == SPS_IDX_WD_CTRL) |=>
            s.wd_err)
        else $error("watchdog error cleared by hardware");

    chk_status_mirror: assert property (
        $past(rstn_i, 2) |-> s.sync2 == $past(phy_status_i, 2))
        else $error("status word does not track macro status");

    chk_busy_ignore: assert property (
        busy && ctl_wr && hwdata_i[SPS_CTL_RESET_LOW] && !phy_ack_i &&
            !wd_fire |=>
            s.wr_start == $past(s.wr_start) &&
            s.rd_start == $past(s.rd_start))
        else $error("start accepted while busy");

    chk_read_wait: assert property (
        s.ph_valid && !s.ph_write && !s.rd_wait |-> ##1 hreadyout_o)
        else $error("read data phase longer than one wait state");

    chk_write_no_wait: assert property (
        s.ph_valid && s.ph_write |-> hreadyout_o)
        else $error("write data phase inserted a wait state");

    chk_reset_values: assert property (
        !$past(rstn_i) |->
            s.reload == SPS_WD_TIMER_RST && s.data == SPS_DATA_RST &&
            s.addr == SPS_ADDR_RST && s.fsm_run && !s.done &&
            !busy && !s.wd_en && !s.wd_err)
        else $error("registers not at reset values after reset");

    chk_reload_store: assert property (
        wr_phase && s.ph_idx == SPS_IDX_WD_TIMER |=>
            s.reload == $past(hwdata_i[15:0]))
        else $error("watchdog timer value did not take written value");

    chk_data_store: assert property (
        wr_phase && s.ph_idx == SPS_IDX_DATA &&
            !(busy && phy_ack_i && s.rd_start) |=>
            s.data == $past(hwdata_i[15:0]))
        else $error("data register did not take written value");

    chk_addr_read: assert property (
        rd_data_ph && s.ph_idx == SPS_IDX_ADDR |=>
            hrdata_o == {16'h0000, $past(s.addr)})
        else $error("address register read back wrong value");

    chk_data_read: assert property (
        rd_data_ph && s.ph_idx == SPS_IDX_DATA |=>
            hrdata_o == {16'h0000, $past(s.data)})
        else $error("data register read back wrong value");

    chk_status_read: assert property (
        rd_data_ph && s.ph_idx == SPS_IDX_STATUS |=>
            hrdata_o == {20'h0_0000, $past(s.sync2)})
        else $error("status word read does not show macro status");

    chk_ctrl_read: assert property (
        rd_data_ph && s.ph_idx == SPS_IDX_CTRL |=>
            hrdata_o[SPS_CTL_DONE] == $past(s.done) &&
            hrdata_o[SPS_CTL_READ_START] == $past(s.rd_start) &&
            hrdata_o[SPS_CTL_WRITE_START] == $past(s.wr_start) &&
            hrdata_o[SPS_CTL_RESET_LOW] == $past(s.fsm_run))
        else $error("control register read back wrong value");

    chk_wd_ctrl_read: assert property (
        rd_data_ph && s.ph_idx == SPS_IDX_WD_CTRL |=>
            hrdata_o == {30'h0, $past(s.wd_en), $past(s.wd_err)})
        else $error("watchdog control read back wrong value");

    chk_wd_count: assert property (
        busy && s.wd_en && s.count != 16'h0000 && !phy_ack_i &&
            !fsm_clear |=> s.count == $past(s.count) - 16'h0001)
        else $error("watchdog did not count down while enabled");

    chk_busy_holds: assert property (
        busy && !phy_ack_i && !wd_fire && !fsm_clear |=> busy)
        else $error("access ended without ack or watchdog expiry");

    chk_write_done: assert property (
        busy && s.wr_start && phy_ack_i && !fsm_clear |=>
            !busy && s.done && !s.wr_start)
        else $error("write completion not flagged");

    chk_err_clear: assert property (
        wr_phase && s.ph_idx == SPS_IDX_WD_CTRL &&
            !hwdata_i[SPS_WD_EN] && !wd_fire |=> !s.wd_err)
        else $error("watchdog error not cleared by disable");

    chk_idle_clear: assert property (
        !busy |-> !s.rd_start && !s.wr_start)
        else $error("start bit left set while idle");

    chk_one_start: assert property (
        busy |-> s.wr_start != s.rd_start)
        else $error("busy access without exactly one start bit");

    chk_run_gate: assert property (
        !s.fsm_run |=> !busy)
        else $error("access started while machine held in reset");

    cov_read_done: cover property (go ##[1:20] busy && phy_ack_i);
    cov_wd_expire: cover property (busy && s.wd_en && s.count == 16'h0000);
    cov_fsm_reset: cover property (busy ##1 !s.fsm_run);
    cov_busy_start: cover property (busy && ctl_wr);
    cov_write_done: cover property (busy && s.wr_start && phy_ack_i);

endmodule

// [verification/sps_phy_model.sv]
// Behavioural model of the PHY internal register space
`timescale 1ns/1ps
module sps_phy_model
    import sps_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Request from the access engine
    input wire sps_phy_req_type phy_req_i,
    // Scenario controls
    input wire logic [3:0] delay_i,
    input wire logic hang_i,
    // Answer
    output logic phy_ack_o,
    output logic [15:0] phy_rdata_o
);
    logic [15:0] mem [0:255];
    logic [3:0] cnt;

    // Read data churns outside the ack cycle so stale values never match
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            phy_ack_o <= 1'b0;
            cnt <= 4'h0;
            phy_rdata_o <= 16'h0000;
        end else if (phy_req_i.valid && !phy_ack_o && !hang_i) begin
            if (cnt == delay_i) begin
                phy_ack_o <= 1'b1;
                cnt <= 4'h0;
                if (phy_req_i.write) begin
                    mem[phy_req_i.addr[7:0]] <= phy_req_i.wdata;
                end else begin
                    phy_rdata_o <= mem[phy_req_i.addr[7:0]];
                end
            end else begin
                cnt <= cnt + 4'h1;
                phy_rdata_o <= ~phy_rdata_o;
            end
        end else begin
            phy_ack_o <= 1'b0;
            cnt <= 4'h0;
            phy_rdata_o <= ~phy_rdata_o;
        end
    end
endmodule

// [verification/serdes_phy_indirect_access_tb_top.sv]
// Self-checking bench for the indirect access block
`timescale 1ns/1ps
module serdes_phy_indirect_access_tb_top
    import sps_pkg::*;
;
    typedef struct {
        logic [31:0] e;
        logic chk;
        string n;
    } sps_note_type;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    sps_phy_req_type phy_req;
    logic phy_ack;
    logic [15:0] phy_rdata;
    sps_phy_stat_type stat = '0;
    logic [3:0] delay = 4'h0;
    logic hang = 1'b0;
    logic rd_ph = 1'b0;
    int failures = 0;
    int samples_checked = 0;
    sps_note_type notes[$];
    sps_note_type note;

    always #50 sys_clk_i = ~sys_clk_i;

    sps_indirect_access dut (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hreadyout),
        .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
        .phy_req_o(phy_req), .phy_ack_i(phy_ack),
        .phy_rdata_i(phy_rdata), .phy_status_i(stat)
    );
    sps_phy_model phy (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .phy_req_i(phy_req),
        .delay_i(delay), .hang_i(hang), .phy_ack_o(phy_ack),
        .phy_rdata_o(phy_rdata)
    );

    task automatic check(input string n, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wait_ready(output logic [31:0] rd);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) failures++;
        rd = hrdata;
        @(posedge sys_clk_i);
    endtask

    task automatic bus(input logic w, input logic [15:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {14'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        wait_ready(rd);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready(rd);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        logic [31:0] rd;
        bus(1'b1, idx, {16'h0000, d}, rd);
    endtask

    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] e,
                          input string n);
        logic [31:0] rd;
        notes.push_back('{e, 1'b1, n});
        bus(1'b0, idx, 32'h0000_0000, rd);
    endtask

    // Poll reads are noted too, so the monitor stays in step
    task automatic poll;
        logic [31:0] rd;
        int n;
        rd = 32'h0000_0000;
        n = 0;
        while (rd[0] !== 1'b1 && n < 40) begin
            notes.push_back('{32'h0000_0000, 1'b0, "poll"});
            bus(1'b0, SPS_IDX_CTRL, 32'h0000_0000, rd);
            n++;
        end
        if (rd[0] !== 1'b1) failures++;
    endtask

    // Falling edge: bus outputs have settled, no race with the design
    always @(negedge sys_clk_i) begin
        if (rd_ph && hreadyout === 1'b1 && notes.size() > 0) begin
            note = notes.pop_front();
            if (note.chk) check(note.n, hrdata, note.e);
            rd_ph = 1'b0;
        end
        if (hsel && htrans[1] && !hwrite && hreadyout === 1'b1) rd_ph = 1'b1;
    end

    task automatic conclude;
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        failures++;
        conclude;
    end

    initial begin
        logic [31:0] v;
        logic [31:0] d;
        v = $urandom(19);
        repeat (20) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_chk(SPS_IDX_DATA, 32'h0000_0000, "data");
        rd_chk(SPS_IDX_ADDR, 32'h0000_0000, "addr");
        rd_chk(SPS_IDX_CTRL, 32'h0000_1000, "ctrl");
        rd_chk(SPS_IDX_STATUS, 32'h0000_0000, "status");
        rd_chk(SPS_IDX_WD_CTRL, 32'h0000_0000, "wd ctrl");
        rd_chk(SPS_IDX_WD_TIMER, 32'h0000_ffff, "wd timer");
        rd_chk(16'hd103, 32'h0000_0000, "unmapped");
        $display("test reset done");
        for (int i = 0; i < 2; i++) begin
            delay <= i ? 4'h5 : 4'h0;
            v = $urandom;
            d = $urandom;
            wr(SPS_IDX_DATA, d[15:0]);
            wr(SPS_IDX_ADDR, {8'h00, v[7:0]});
            rd_chk(SPS_IDX_ADDR, {24'h00_0000, v[7:0]}, "addr");
            wr(SPS_IDX_CTRL, 16'h1100);
            poll;
            rd_chk(SPS_IDX_CTRL, 32'h0000_1001, "ctrl wr");
            wr(SPS_IDX_DATA, 16'h0000);
            wr(SPS_IDX_CTRL, 16'h1010);
            poll;
            rd_chk(SPS_IDX_CTRL, 32'h0000_1001, "ctrl rd");
            rd_chk(SPS_IDX_DATA, {16'h0000, d[15:0]}, "rd data");
        end
        $display("test access done");
        delay <= 4'hf;
        // A wrongly taken write start would leave this value behind
        wr(SPS_IDX_DATA, ~d[15:0]);
        wr(SPS_IDX_CTRL, 16'h1010);
        rd_chk(SPS_IDX_CTRL, 32'h0000_1010, "ctrl busy");
        wr(SPS_IDX_CTRL, 16'h1100);
        poll;
        rd_chk(SPS_IDX_CTRL, 32'h0000_1001, "start ignored");
        rd_chk(SPS_IDX_DATA, {16'h0000, d[15:0]}, "busy data");
        $display("test busy done");
        hang <= 1'b1;
        wr(SPS_IDX_CTRL, 16'h1010);
        wr(SPS_IDX_CTRL, 16'h0000);
        rd_chk(SPS_IDX_CTRL, 32'h0000_0000, "ctrl held");
        @(negedge sys_clk_i);
        check("phy valid", {31'h0, phy_req.valid}, 32'h0000_0000);
        @(posedge sys_clk_i);
        wr(SPS_IDX_CTRL, 16'h1000);
        rd_chk(SPS_IDX_CTRL, 32'h0000_1000, "ctrl released");
        $display("test fsm reset done");
        wr(SPS_IDX_WD_TIMER, 16'h0003);
        rd_chk(SPS_IDX_WD_TIMER, 32'h0000_0003, "wd timer");
        wr(SPS_IDX_CTRL, 16'h1010);
        repeat (20) @(posedge sys_clk_i);
        rd_chk(SPS_IDX_CTRL, 32'h0000_1010, "wd off");
        wr(SPS_IDX_CTRL, 16'h0000);
        wr(SPS_IDX_CTRL, 16'h1000);
        wr(SPS_IDX_WD_CTRL, 16'h0002);
        wr(SPS_IDX_CTRL, 16'h1010);
        poll;
        rd_chk(SPS_IDX_WD_CTRL, 32'h0000_0003, "wd err");
        rd_chk(SPS_IDX_DATA, {16'h0000, d[15:0]}, "wd data");
        wr(SPS_IDX_WD_CTRL, 16'h0001);
        rd_chk(SPS_IDX_WD_CTRL, 32'h0000_0000, "wd err ro");
        hang <= 1'b0;
        $display("test watchdog done");
        for (int i = 0; i < 4; i++) begin
            v = $urandom;
            stat <= v[11:0];
            wr(SPS_IDX_STATUS, 16'hffff);
            repeat (4) @(posedge sys_clk_i);
            rd_chk(SPS_IDX_STATUS, {20'h0_0000, v[11:0]}, "st");
        end
        $display("test status done");
        repeat (2) @(posedge sys_clk_i);
        conclude;
    end
endmodule
